// ### common/brad_defs.vh
// constants and field layout of the bridge address decoder
// Operation
// - addresses pass unchanged; anything not claimed downstream belongs upstream.
// - with I/O enable clear, primary-side I/O transactions are never forwarded.
// - with master enable clear, secondary-side I/O and memory are ignored.
// - I/O inside window goes downstream; I/O outside window goes upstream.
// - I/O base above limit disables window; all secondary I/O goes upstream.
// - I/O window 4KB grained: base low bits zero, limit low bits FFFh.
// - I/O base low byte: upper nibble holds bits 15:12, lower nibble reads 1h.
// - writable 16-bit register supplies I/O base bits 31:16.
// - I/O limit from low byte (nibble plus 1h) and writable upper 16 bits.
// - after reset I/O base is 0000 0000h and limit 0000 0FFFh.
// - ISA mode affects only in-window I/O addresses with bits 31:16 zero.
// - ISA mode forwards downstream only the low 256 bytes per 1KB block.
// - ISA mode with master enable sends upper 768 bytes per block upstream.
// - memory goes downstream only while memory enable is set.
// - non-prefetchable space prefetches only for read line or read multiple.
// - memory inside MMIO window: primary forwarded down, secondary ignored.
// - memory outside MMIO window: primary ignored, secondary up unless otherwise claimed.
// - MMIO window is 32-bit only with 1MB granularity, up to 4GB.
// - MMIO base/limit carry bits 31:20 in upper 12 bits; low nibble zero.
// - after reset MMIO base is 0000 0000h and limit 000F FFFFh.
// - MMIO base above limit disables the MMIO window.
`ifndef BRAD_DEFS_VH
`define BRAD_DEFS_VH

// configuration byte offsets
`define BRAD_OFF_IO_BASE_LOW 8'h1c
`define BRAD_OFF_IO_LIMIT_LOW 8'h1d
`define BRAD_OFF_MMIO_BASE 8'h20
`define BRAD_OFF_MMIO_LIMIT 8'h22
`define BRAD_OFF_IO_BASE_HIGH 8'h30
`define BRAD_OFF_IO_LIMIT_HIGH 8'h32
// dword holding each offset pair
`define BRAD_DW_IO_LOW 6'h07
`define BRAD_DW_MMIO 6'h08
`define BRAD_DW_IO_HIGH 6'h0c

// field values
`define BRAD_IO_DECODE_32 4'h1
`define BRAD_NIBBLE_ZERO 4'h0
`define BRAD_IO_BASE_FILL 12'h000
`define BRAD_IO_LIMIT_FILL 12'hfff
`define BRAD_MMIO_BASE_FILL 20'h0_0000
`define BRAD_MMIO_LIMIT_FILL 20'hf_ffff
`define BRAD_ISA_HIGH_ZERO 16'h0000
`define BRAD_ISA_LOW_QUARTER 2'h0

// reset values of writable fields
`define BRAD_RST_NIBBLE 4'h0
`define BRAD_RST_UPPER16 16'h0000
`define BRAD_RST_MMIO12 12'h000
`define BRAD_RST_DATA32 32'h0000_0000

// bus commands
`define BRAD_CMD_MEM_READ 4'h6
`define BRAD_CMD_MEM_READ_LINE 4'he
`define BRAD_CMD_MEM_READ_MULT 4'hc

`endif

// ### hdl/brad_window_cmp.v
// inclusive base/limit window comparator
module brad_window_cmp #(
    parameter WIDTH = 32
) (
    // address under test
    input wire [WIDTH-1:0] addr,
    // expanded window bounds
    input wire [WIDTH-1:0] base,
    input wire [WIDTH-1:0] limit,
    // result
    output wire hit
);

    // base above limit turns the window off entirely
    assign hit = (base <= limit) && (addr >= base) && (addr <= limit);

endmodule // brad_window_cmp

// ### hdl/brad_addr_decoder.v
// address decoder of the bridge: window registers and forwarding decisions
`include "brad_defs.vh"

module brad_addr_decoder #(
    parameter ADDR_WIDTH = 32
) (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // configuration space access
    input wire cfgWrite,
    input wire cfgRead,
    input wire [7:0] cfgAddr,
    input wire [3:0] cfgByteEn,
    input wire [31:0] cfgWriteData,
    output reg [31:0] cfgReadData,
    output reg cfgReadValid,
    // command and bridge control bits
    input wire ioEnable,
    input wire memEnable,
    input wire masterEnable,
    input wire isaEnable,
    // claims made by decode logic outside this block
    input wire prefetchHit,
    input wire vgaClaim,
    // primary-side transaction
    input wire priValid,
    input wire priIsIo,
    input wire [3:0] priCmd,
    input wire [ADDR_WIDTH-1:0] priAddr,
    // primary-side decision
    output reg priDone,
    output reg priForwardDown,
    output reg priPrefetchOk,
    output reg priSingleData,
    output reg [ADDR_WIDTH-1:0] priAddrOut,
    // secondary-side transaction
    input wire secValid,
    input wire secIsIo,
    input wire [ADDR_WIDTH-1:0] secAddr,
    // secondary-side decision
    output reg secDone,
    output reg secForwardUp,
    output reg [ADDR_WIDTH-1:0] secAddrOut
);

    // config writes reach the decode on the next cycle; moving a window while
    // traffic flows mixes old and new decisions, so software must program the
    // windows before raising the enables and touch them later only when idle

    // writable window fields
    reg [3:0] ioBaseNibble;
    reg [3:0] ioLimitNibble;
    reg [15:0] ioBaseUpper;
    reg [15:0] ioLimitUpper;
    reg [11:0] mmioBaseField;
    reg [11:0] mmioLimitField;

    // decode of the configuration dword
    wire [5:0] cfgDword;
    wire selIoLow;
    wire selMmio;
    wire selIoHigh;

    // expanded window bounds
    wire [31:0] ioBaseFull;
    wire [31:0] ioLimitFull;
    wire [31:0] mmioBaseFull;
    wire [31:0] mmioLimitFull;

    // raw window hits
    wire priIoHit;
    wire secIoHit;
    wire priMmioHit;
    wire secMmioHit;

    // ISA aliasing and next decisions
    wire priIsaBlocked;
    wire secIsaBlocked;
    reg next_priForwardDown;
    reg next_priPrefetchOk;
    reg next_priSingleData;
    reg next_secForwardUp;
    reg [31:0] next_cfgReadData;

    // per-lane write strobes
    wire wrIoBaseLow;
    wire wrIoLimitLow;
    wire wrMmioBaseLow;
    wire wrMmioBaseHigh;
    wire wrMmioLimitLow;
    wire wrMmioLimitHigh;
    wire wrIoBaseUpperLow;
    wire wrIoBaseUpperHigh;
    wire wrIoLimitUpperLow;
    wire wrIoLimitUpperHigh;

    // readable views with the fixed bits merged in
    wire [7:0] ioBaseLowView;
    wire [7:0] ioLimitLowView;
    wire [15:0] mmioBaseView;
    wire [15:0] mmioLimitView;

    // side decisions before valid and enable gating
    wire priIoClaim;
    wire priMemClaim;
    wire priBurstRead;
    wire priPlainRead;
    wire secIoUp;
    wire secOtherClaim;
    wire secMemUp;

    // which register dword the access names
    assign cfgDword = cfgAddr[7:2];
    assign selIoLow = (cfgDword == `BRAD_DW_IO_LOW);
    assign selMmio = (cfgDword == `BRAD_DW_MMIO);
    assign selIoHigh = (cfgDword == `BRAD_DW_IO_HIGH);

    // one strobe per byte lane; a lane left disabled keeps its old value
    assign wrIoBaseLow = cfgWrite && selIoLow && cfgByteEn[0];
    assign wrIoLimitLow = cfgWrite && selIoLow && cfgByteEn[1];
    assign wrMmioBaseLow = cfgWrite && selMmio && cfgByteEn[0];
    assign wrMmioBaseHigh = cfgWrite && selMmio && cfgByteEn[1];
    assign wrMmioLimitLow = cfgWrite && selMmio && cfgByteEn[2];
    assign wrMmioLimitHigh = cfgWrite && selMmio && cfgByteEn[3];
    assign wrIoBaseUpperLow = cfgWrite && selIoHigh && cfgByteEn[0];
    assign wrIoBaseUpperHigh = cfgWrite && selIoHigh && cfgByteEn[1];
    assign wrIoLimitUpperLow = cfgWrite && selIoHigh && cfgByteEn[2];
    assign wrIoLimitUpperHigh = cfgWrite && selIoHigh && cfgByteEn[3];

    // I/O low bytes; the read-only nibbles are simply not stored
    always @(posedge clock) begin
        if (!rst_n) begin
            ioBaseNibble <= `BRAD_RST_NIBBLE;
            ioLimitNibble <= `BRAD_RST_NIBBLE;
        end else begin
            if (wrIoBaseLow) begin
                ioBaseNibble <= cfgWriteData[7:4];
            end
            if (wrIoLimitLow) begin
                ioLimitNibble <= cfgWriteData[15:12];
            end
        end
    end

    // memory-mapped I/O bounds; the low nibble of each half is hardwired zero
    always @(posedge clock) begin
        if (!rst_n) begin
            mmioBaseField <= `BRAD_RST_MMIO12;
            mmioLimitField <= `BRAD_RST_MMIO12;
        end else begin
            if (wrMmioBaseLow) begin
                mmioBaseField[3:0] <= cfgWriteData[7:4];
            end
            if (wrMmioBaseHigh) begin
                mmioBaseField[11:4] <= cfgWriteData[15:8];
            end
            if (wrMmioLimitLow) begin
                mmioLimitField[3:0] <= cfgWriteData[23:20];
            end
            if (wrMmioLimitHigh) begin
                mmioLimitField[11:4] <= cfgWriteData[31:24];
            end
        end
    end

    // upper I/O address halves, fully writable per byte
    always @(posedge clock) begin
        if (!rst_n) begin
            ioBaseUpper <= `BRAD_RST_UPPER16;
            ioLimitUpper <= `BRAD_RST_UPPER16;
        end else begin
            if (wrIoBaseUpperLow) begin
                ioBaseUpper[7:0] <= cfgWriteData[7:0];
            end
            if (wrIoBaseUpperHigh) begin
                ioBaseUpper[15:8] <= cfgWriteData[15:8];
            end
            if (wrIoLimitUpperLow) begin
                ioLimitUpper[7:0] <= cfgWriteData[23:16];
            end
            if (wrIoLimitUpperHigh) begin
                ioLimitUpper[15:8] <= cfgWriteData[31:24];
            end
        end
    end

    // fixed bits merged into each readable field
    assign ioBaseLowView = {ioBaseNibble, `BRAD_IO_DECODE_32};
    assign ioLimitLowView = {ioLimitNibble, `BRAD_IO_DECODE_32};
    assign mmioBaseView = {mmioBaseField, `BRAD_NIBBLE_ZERO};
    assign mmioLimitView = {mmioLimitField, `BRAD_NIBBLE_ZERO};

    // read data; unmapped dwords read zero, lanes are returned whole
    always @* begin
        next_cfgReadData = `BRAD_RST_DATA32;
        if (selIoLow) begin
            next_cfgReadData[7:0] = ioBaseLowView;
            next_cfgReadData[15:8] = ioLimitLowView;
        end else if (selMmio) begin
            next_cfgReadData[15:0] = mmioBaseView;
            next_cfgReadData[31:16] = mmioLimitView;
        end else if (selIoHigh) begin
            next_cfgReadData[15:0] = ioBaseUpper;
            next_cfgReadData[31:16] = ioLimitUpper;
        end
    end

    // read strobe echoed one cycle later as the answer
    always @(posedge clock) begin
        if (!rst_n) begin
            cfgReadValid <= 1'b0;
        end else begin
            cfgReadValid <= cfgRead;
        end
    end

    // data caught only on reads and held; a same-cycle write is not yet seen
    always @(posedge clock) begin
        if (!rst_n) begin
            cfgReadData <= `BRAD_RST_DATA32;
        end else if (cfgRead) begin
            cfgReadData <= next_cfgReadData;
        end
    end

    // window bounds with implied low bits, 4KB for I/O and 1MB for memory
    assign ioBaseFull = {ioBaseUpper, ioBaseNibble, `BRAD_IO_BASE_FILL};
    assign ioLimitFull = {ioLimitUpper, ioLimitNibble, `BRAD_IO_LIMIT_FILL};
    assign mmioBaseFull = {mmioBaseField, `BRAD_MMIO_BASE_FILL};
    assign mmioLimitFull = {mmioLimitField, `BRAD_MMIO_LIMIT_FILL};

    // one comparator per side and window so both sides decode in the same clock
    brad_window_cmp #(
        .WIDTH(32)
    ) u_pri_io (
        .addr(priAddr[31:0]),
        .base(ioBaseFull),
        .limit(ioLimitFull),
        .hit(priIoHit)
    );

    brad_window_cmp #(
        .WIDTH(32)
    ) u_sec_io (
        .addr(secAddr[31:0]),
        .base(ioBaseFull),
        .limit(ioLimitFull),
        .hit(secIoHit)
    );

    brad_window_cmp #(
        .WIDTH(32)
    ) u_pri_mmio (
        .addr(priAddr[31:0]),
        .base(mmioBaseFull),
        .limit(mmioLimitFull),
        .hit(priMmioHit)
    );

    brad_window_cmp #(
        .WIDTH(32)
    ) u_sec_mmio (
        .addr(secAddr[31:0]),
        .base(mmioBaseFull),
        .limit(mmioLimitFull),
        .hit(secMmioHit)
    );

    // ISA aliasing: below 64KB, top 768 bytes of each 1KB block stay upstream
    assign priIsaBlocked = isaEnable && (priAddr[31:16] == `BRAD_ISA_HIGH_ZERO)
        && (priAddr[9:8] != `BRAD_ISA_LOW_QUARTER);
    assign secIsaBlocked = isaEnable && (secAddr[31:16] == `BRAD_ISA_HIGH_ZERO)
        && (secAddr[9:8] != `BRAD_ISA_LOW_QUARTER);

    // primary claims before valid and enable gating
    assign priIoClaim = priIoHit && !priIsaBlocked;
    assign priMemClaim = priMmioHit;
    // burst reads may prefetch; a plain read gets one data phase
    assign priBurstRead = (priCmd == `BRAD_CMD_MEM_READ_LINE) || (priCmd == `BRAD_CMD_MEM_READ_MULT);
    assign priPlainRead = (priCmd == `BRAD_CMD_MEM_READ);

    // secondary: no gaps, so whatever is not owned below goes up
    assign secIoUp = !secIoHit || secIsaBlocked;
    // memory owned by the prefetchable window or VGA decode stays below
    assign secOtherClaim = prefetchHit || vgaClaim;
    assign secMemUp = !secMmioHit && !secOtherClaim;

    // primary side: only window hits are claimed, everything else ignored
    always @* begin
        next_priForwardDown = 1'b0;
        next_priPrefetchOk = 1'b0;
        next_priSingleData = 1'b0;
        if (priValid) begin
            if (priIsIo) begin
                // disabled window never hits, so nothing goes down
                next_priForwardDown = ioEnable && priIoClaim;
            end else begin
                next_priForwardDown = memEnable && priMemClaim;
                next_priPrefetchOk = memEnable && priMemClaim && priBurstRead;
                next_priSingleData = memEnable && priMemClaim && priPlainRead;
            end
        end
    end

    // secondary side: anything not owned downstream goes up, master enable gating
    always @* begin
        next_secForwardUp = 1'b0;
        if (secValid && masterEnable) begin
            if (secIsIo) begin
                // in-window I/O stays below unless ISA aliasing returns it
                next_secForwardUp = secIoUp;
            end else begin
                // memory claimed by another window stays below
                next_secForwardUp = secMemUp;
            end
        end
    end

    // primary decisions registered, one cycle after the request
    always @(posedge clock) begin
        if (!rst_n) begin
            priDone <= 1'b0;
            priForwardDown <= 1'b0;
            priPrefetchOk <= 1'b0;
            priSingleData <= 1'b0;
            priAddrOut <= {ADDR_WIDTH{1'b0}};
        end else begin
            priDone <= priValid;
            priForwardDown <= next_priForwardDown;
            priPrefetchOk <= next_priPrefetchOk;
            priSingleData <= next_priSingleData;
            // address crosses untranslated and is held until the next request
            if (priValid) begin
                priAddrOut <= priAddr;
            end
        end
    end

    // secondary decisions registered in the same clock as the primary ones
    always @(posedge clock) begin
        if (!rst_n) begin
            secDone <= 1'b0;
            secForwardUp <= 1'b0;
            secAddrOut <= {ADDR_WIDTH{1'b0}};
        end else begin
            secDone <= secValid;
            secForwardUp <= next_secForwardUp;
            if (secValid) begin
                secAddrOut <= secAddr;
            end
        end
    end

endmodule // brad_addr_decoder

// ### verification/brad_addr_decoder_chk.sv
// port-level assertions of the bridge address decoder
module brad_chk (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // enables and outside claims
    input wire ioEnable,
    input wire memEnable,
    input wire masterEnable,
    input wire isaEnable,
    input wire prefetchHit,
    input wire vgaClaim,
    // primary side
    input wire priValid,
    input wire priIsIo,
    input wire [31:0] priAddr,
    input wire priDone,
    input wire priForwardDown,
    input wire [31:0] priAddrOut,
    // secondary side
    input wire secValid,
    input wire secIsIo,
    input wire [31:0] secAddr,
    input wire secForwardUp
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // every primary request gets its answer one cycle later
    property p_pri_done; priValid |=> priDone; endproperty
    a_pri_done: assert property (p_pri_done) else $error("no primary answer");
    property p_io_off; priValid && priIsIo && !ioEnable |=> !priForwardDown; endproperty
    a_io_off: assert property (p_io_off) else $error("io forwarded while off");
    property p_master; secValid && !masterEnable |=> !secForwardUp; endproperty
    a_master: assert property (p_master) else $error("upstream without master");
    property p_mem_en; priValid && !priIsIo && !memEnable |=> !priForwardDown; endproperty
    a_mem_en: assert property (p_mem_en) else $error("memory forwarded while off");
    // address copied untranslated
    property p_addr; priValid |=> priAddrOut == $past(priAddr); endproperty
    a_addr: assert property (p_addr) else $error("address changed");
    property p_claim; secValid && !secIsIo && (prefetchHit || vgaClaim) |=> !secForwardUp; endproperty
    a_claim: assert property (p_claim) else $error("claimed memory sent up");
    // isa holes below 64KB: never down, always up when mastering
    property p_isa_dn;
        priValid && priIsIo && isaEnable && priAddr[31:16] == 16'h0 && priAddr[9:8] != 2'h0 |=> !priForwardDown;
    endproperty
    a_isa_dn: assert property (p_isa_dn) else $error("isa hole sent down");
    property p_isa_up;
        secValid && secIsIo && masterEnable && isaEnable && secAddr[31:16] == 16'h0 && secAddr[9:8] != 2'h0
            |=> secForwardUp;
    endproperty
    a_isa_up: assert property (p_isa_up) else $error("isa hole not sent up");
endmodule // brad_chk

bind brad_addr_decoder brad_chk brad_chk_inst (.clock, .rst_n, .ioEnable, .memEnable, .masterEnable, .isaEnable,
    .prefetchHit, .vgaClaim, .priValid, .priIsIo, .priAddr, .priDone, .priForwardDown, .priAddrOut,
    .secValid, .secIsIo, .secAddr, .secForwardUp);

// ### verification/brad_init_model.sv
// initiator model presenting one transaction per side per call
module brad_init_model (
    // clock
    input wire clock,
    // primary initiator
    output logic priValid,
    output logic priIsIo,
    output logic [3:0] priCmd,
    output logic [31:0] priAddr,
    // secondary initiator
    output logic secValid,
    output logic secIsIo,
    output logic [31:0] secAddr
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle buses at time zero
    initial begin
        priValid = 0;
        priIsIo = 0;
        priCmd = 4'h0;
        priAddr = 32'h0;
        secValid = 0;
        secIsIo = 0;
        secAddr = 32'h0;
    end
    // held one full cycle, changed only at falling edges
    task automatic issue(input logic pIo, input logic [3:0] cmd, input logic [31:0] pA,
                         input logic sIo, input logic [31:0] sA);
        @(negedge clock);
        priValid = 1;
        priIsIo = pIo;
        priCmd = cmd;
        priAddr = pA;
        secValid = 1;
        secIsIo = sIo;
        secAddr = sA;
        @(negedge clock);
        priValid = 0;
        secValid = 0;
        // released lines show the inverse, not a stale address
        priAddr = ~pA;
        secAddr = ~sA;
    endtask
endmodule // brad_init_model

// ### verification/brad_addr_decoder_tb.sv
// self-checking testbench of the bridge address decoder
`include "brad_defs.vh"
module brad_addr_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 0;
    logic rst_n = 0;
    logic cfgWrite = 0;
    logic cfgRead = 0;
    logic [7:0] cfgAddr = 8'h0;
    logic [3:0] cfgByteEn = 4'h0;
    logic [31:0] cfgWriteData = 32'h0;
    logic ioEnable = 0;
    logic memEnable = 0;
    logic masterEnable = 0;
    logic isaEnable = 0;
    logic prefetchHit = 0;
    logic vgaClaim = 0;
    logic [31:0] cfgReadData, priAddr, priAddrOut, secAddr, secAddrOut;
    logic cfgReadValid, priValid, priIsIo, secValid, secIsIo;
    logic priDone, priForwardDown, priPrefetchOk, priSingleData, secDone, secForwardUp;
    logic [3:0] priCmd;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    always #2.5 clock = ~clock;

    brad_addr_decoder brad_addr_decoder_inst (.clock, .rst_n, .cfgWrite, .cfgRead, .cfgAddr, .cfgByteEn,
        .cfgWriteData, .cfgReadData, .cfgReadValid, .ioEnable, .memEnable, .masterEnable, .isaEnable,
        .prefetchHit, .vgaClaim, .priValid, .priIsIo, .priCmd, .priAddr, .priDone, .priForwardDown,
        .priPrefetchOk, .priSingleData, .priAddrOut, .secValid, .secIsIo, .secAddr, .secDone,
        .secForwardUp, .secAddrOut);
    brad_init_model brad_init_model_inst (.clock, .priValid, .priIsIo, .priCmd, .priAddr, .secValid,
        .secIsIo, .secAddr);

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard, far above the roughly 80 cycles needed
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            final_report;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cw(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge clock);
        cfgWrite = 1;
        cfgAddr = a;
        cfgByteEn = be;
        cfgWriteData = d;
        @(negedge clock);
        cfgWrite = 0;
    endtask
    task automatic cr(input logic [7:0] a, input logic [31:0] e);
        @(negedge clock);
        cfgRead = 1;
        cfgAddr = a;
        @(negedge clock);
        cfgRead = 0;
        chk({31'h0, cfgReadValid}, 32'h1);
        chk(cfgReadData, e);
    endtask
    // e holds forward-down, up, prefetch, single-data
    task automatic tx(input logic pIo, input logic [3:0] cmd, input logic [31:0] pA,
                      input logic sIo, input logic [31:0] sA, input logic [3:0] e);
        brad_init_model_inst.issue(pIo, cmd, pA, sIo, sA);
        chk({26'h0, priDone, secDone, priForwardDown, secForwardUp, priPrefetchOk, priSingleData}, {26'h0, 2'h3, e});
        chk(priAddrOut, pA);
        chk(secAddrOut, sA);
    endtask
    task automatic t_reset;
        cr(8'h1c, 32'h0000_0101);
        cr(8'h20, 32'h0);
        cr(8'h30, 32'h0);
        cw(8'h40, 4'hf, 32'hffff_ffff);
        cr(8'h40, 32'h0);
        // windows stay untouched until enables go up
        ioEnable = 1;
        memEnable = 1;
        masterEnable = 1;
        tx(1, 4'h2, 32'h0000_0fff, 1, 32'h0000_1000, 4'hc);
        tx(0, `BRAD_CMD_MEM_READ, 32'h000f_ffff, 0, 32'h0010_0000, 4'hd);
        $display("t_reset done");
    endtask
    task automatic t_io;
        cw(8'h1c, 4'hf, 32'h0000_3f2f);
        cr(8'h1c, 32'h0000_3121);
        cw(8'h30, 4'h3, 32'h0002_0001);
        cr(8'h30, 32'h0000_0001);
        cw(8'h30, 4'hc, 32'h0001_ffff);
        cr(8'h30, 32'h0001_0001);
        tx(1, 4'h2, 32'h0001_2000, 1, 32'h0001_1fff, 4'hc);
        tx(1, 4'h2, 32'h0001_3fff, 1, 32'h0001_3fff, 4'h8);
        tx(1, 4'h2, 32'h0001_4000, 1, 32'h0001_2000, 4'h0);
        isaEnable = 1;
        tx(1, 4'h2, 32'h0001_2300, 1, 32'h0001_2300, 4'h8);
        isaEnable = 0;
        ioEnable = 0;
        masterEnable = 0;
        tx(1, 4'h2, 32'h0001_2000, 1, 32'h0001_4000, 4'h0);
        ioEnable = 1;
        masterEnable = 1;
        cw(8'h30, 4'hf, 32'h0001_0002);
        tx(1, 4'h2, 32'h0001_2000, 1, 32'h0001_2000, 4'h4);
        $display("t_io done");
    endtask
    task automatic t_isa;
        cw(8'h1c, 4'hf, 32'h0000_f000);
        cw(8'h30, 4'hf, 32'h0);
        isaEnable = 1;
        tx(1, 4'h2, 32'h0000_0400, 1, 32'h0000_0100, 4'hc);
        tx(1, 4'h2, 32'h0000_03ff, 1, 32'h0000_04ff, 4'h0);
        isaEnable = 0;
        tx(1, 4'h2, 32'h0000_0300, 1, 32'h0000_0300, 4'h8);
        $display("t_isa done");
    endtask
    task automatic t_mem;
        cw(8'h20, 4'hf, 32'h002f_001f);
        cr(8'h20, 32'h0020_0010);
        tx(0, `BRAD_CMD_MEM_READ, 32'h0010_0000, 0, 32'h0010_0000, 4'h9);
        tx(0, `BRAD_CMD_MEM_READ_LINE, 32'h002f_ffff, 0, 32'h0030_0000, 4'he);
        tx(0, `BRAD_CMD_MEM_READ_MULT, 32'h000f_ffff, 0, 32'h000f_ffff, 4'h4);
        prefetchHit = 1;
        tx(0, `BRAD_CMD_MEM_READ_MULT, 32'h0020_0000, 0, 32'h0040_0000, 4'ha);
        prefetchHit = 0;
        vgaClaim = 1;
        tx(0, `BRAD_CMD_MEM_READ, 32'h0030_0000, 0, 32'h0040_0000, 4'h0);
        vgaClaim = 0;
        memEnable = 0;
        tx(0, `BRAD_CMD_MEM_READ_LINE, 32'h0020_0000, 0, 32'h0050_0000, 4'h4);
        memEnable = 1;
        cw(8'h20, 4'hf, 32'h0010_0020);
        tx(0, `BRAD_CMD_MEM_READ, 32'h0018_0000, 0, 32'h0018_0000, 4'h4);
        $display("t_mem done");
    endtask

    initial begin
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst_n = 1;
        t_reset;
        t_io;
        t_isa;
        t_mem;
        final_report;
    end
endmodule // brad_addr_decoder_tb
